// >>> scm_pkg.sv
// Constants, field layouts and carrier types for the serial mode/clock block.
// Assumes one 125 MHz core clock and an 8-bit register port.
package scm_pkg;

  // ************************************************************
  // Register port
  // ************************************************************
  localparam int ADDR_W = 8;
  localparam int DATA_W = 8;

  localparam logic [7:0] OFF_FMT  = 8'h00;
  localparam logic [7:0] OFF_CTL  = 8'h04;
  localparam logic [7:0] OFF_DIV  = 8'h08;
  localparam logic [7:0] OFF_TXD  = 8'h0C;
  localparam logic [7:0] OFF_RXD  = 8'h10;
  localparam logic [7:0] OFF_STAT = 8'h14;
  localparam logic [7:0] OFF_CLR  = 8'h18;
  localparam logic [7:0] OFF_IEN  = 8'h1C;
  localparam logic [7:0] OFF_LIVE = 8'h20;

  localparam logic [7:0] REG_RST  = 8'h00;

  // ************************************************************
  // Frame timing
  // ************************************************************
  localparam logic [3:0] PH_SAMPLE  = 4'h7;
  localparam logic [3:0] PH_LAST    = 4'hF;
  localparam logic [3:0] DATA_MAX   = 4'h8;
  localparam logic [3:0] DATA_SHORT = 4'h7;
  localparam logic [3:0] FRAME_BITS = 4'hC;
  localparam logic [3:0] SYNC_LAST  = 4'h7;
  localparam logic [2:0] HALF_LAST  = 3'h7;
  localparam logic [3:0] ONE4       = 4'h1;
  localparam logic [7:0] MASK7      = 8'h7F;
  localparam logic [7:0] MASK8      = 8'hFF;

  // ************************************************************
  // Carrier types
  // ************************************************************
  typedef struct packed {
    logic       mode;
    logic       chr;
    logic       pe;
    logic       odd;
    logic       stop;
    logic       mp;
    logic [1:0] rsv;
  } scm_fmt_t;

  typedef struct packed {
    logic       rsv7;
    logic       mpb_tx;
    logic       txen;
    logic       rxen;
    logic [1:0] rsv;
    logic       cke_hi;
    logic       cke_lo;
  } scm_ctl_t;

  typedef struct packed {
    logic [1:0] rsv;
    logic       brk;
    logic       perr;
    logic       ferr;
    logic       ovr;
    logic       tx_done;
    logic       rx_ready;
  } scm_evt_t;

  typedef struct packed {
    logic [11:0] bits;
    logic [3:0]  len;
  } scm_frame_t;

  typedef struct packed {
    logic [7:0] data;
    logic       multiproc_frame_bit;
    logic       perr;
    logic       ferr;
    logic       brk;
  } scm_rx_res_t;

  typedef enum logic [1:0] {
    RX_IDLE  = 2'h0,
    RX_START = 2'h1,
    RX_DATA  = 2'h2
  } scm_rx_state_t;

endpackage

// >>> scm_serial.sv
// Serial interface with mode, frame-format and clock-source selection.
// Assumes a same-clock register master; rxd and sck arrive from pins.
//
// Behaviour
// - Format bit 7 selects asynchronous (0) or clock synchronous (1) mode.
// - Asynchronous bit 6 selects 8 data bits (0) or 7 (1).
// - Bit 5 adds a parity bit after data when multiprocessor format is off.
// - Asynchronous bit 3 selects one (0) or two (1) stop bits.
// - Bit 2 adds a multiprocessor bit instead of parity; parity enable ignored.
// - Asynchronous receive flags framing, parity, overrun and break.
// - Async, clock selects 00: baud generator clock, serial clock pin unused.
// - Async, selects 01: baud generator clock, bit-rate clock driven out.
// - Async, upper select 1: serial clock pin input clocks, generator bypassed.
// - Synchronous mode: exactly 8 data bits, no parity, multiprocessor or stop.
// - Synchronous receive flags only overrun.
// - Sync, upper select 0: generator clock driven out on serial clock pin.
// - Sync, upper select 1: far side supplies clock; generator unused.
// - Serial clock pin role applies only when pin routing assigns it.
// - Async frame: low start, data LSB first, option bit, high stops.
// - Receiver syncs on start falling edge, samples on eighth of sixteen ticks.
//
// Decided for this implementation: the placing of the registers and the plain strobed port.
`timescale 1ns/1ps
module scm_serial (
  input  wire logic                        core_clk,
  input  wire logic                        rst_b,
  input  wire logic [scm_pkg::ADDR_W-1:0]  addr,
  input  wire logic [scm_pkg::DATA_W-1:0]  wdata,
  input  wire logic                        wr_stb,
  input  wire logic                        rd_stb,
  output logic      [scm_pkg::DATA_W-1:0]  rdata,
  input  wire logic                        rxd,
  output logic                             txd,
  input  wire logic                        sck_i,
  output logic                             sck_o,
  output logic                             sck_oe,
  input  wire logic                        sck_routed,
  output logic                             irq
);
  import scm_pkg::*;

  // ************************************************************
  // Format helpers
  // ************************************************************
  function automatic logic [3:0] data_bits(scm_fmt_t f);
    data_bits = (f.chr & ~f.mode) ? DATA_SHORT : DATA_MAX;
  endfunction

  function automatic logic [7:0] dmask(logic [3:0] nd);
    dmask = (nd == DATA_SHORT) ? MASK7 : MASK8;
  endfunction

  // Bits after the start bit up to and including the first stop bit
  function automatic logic [3:0] rx_bits(scm_fmt_t f);
    if (f.mode)
      rx_bits = DATA_MAX;
    else
      rx_bits = data_bits(f) + {3'h0, f.pe | f.mp} + ONE4;
  endfunction

  function automatic scm_frame_t make_frame(scm_fmt_t f, logic [7:0] d, logic multiproc_frame_bit);
    scm_frame_t r;
    logic [3:0] nd;
    logic [3:0] p;
    nd     = data_bits(f);
    r.bits = '1;
    r.len  = DATA_MAX;
    p      = nd + ONE4;
    if (f.mode) begin
      r.bits = {4'hF, d};
    end else begin
      r.bits[0] = 1'h0;
      for (int i = 0; i < 8; i++) begin
        if (4'(i) < nd) begin
          r.bits[i + 1] = d[i];
        end
      end
      if (f.mp)
        r.bits[p] = multiproc_frame_bit;
      else if (f.pe)
        r.bits[p] = (^(d & dmask(nd))) ^ f.odd;
      r.len = rx_bits(f) + ONE4 + {3'h0, f.stop};
    end
    return r;
  endfunction

  function automatic scm_rx_res_t decode_rx(scm_fmt_t f, logic [11:0] sh);
    scm_rx_res_t r;
    logic [3:0]  n;
    logic [3:0]  nd;
    logic [11:0] w;
    logic        opt;
    logic        stp;
    n      = rx_bits(f);
    nd     = data_bits(f);
    w      = sh >> (FRAME_BITS - n);
    opt    = w[nd];
    stp    = w[n - ONE4];
    r.data = w[7:0] & dmask(nd);
    r.multiproc_frame_bit  = ~f.mode & f.mp & opt;
    r.perr = ~f.mode & ~f.mp & f.pe & ((^r.data ^ f.odd) != opt);
    r.ferr = ~f.mode & ~stp;
    r.brk  = ~f.mode & (w == 12'h000);
    return r;
  endfunction

  // ************************************************************
  // Registers and state
  // ************************************************************
  scm_fmt_t      fmt;
  scm_ctl_t      ctl;
  scm_evt_t      stat;
  scm_evt_t      ien;
  scm_rx_state_t rx_st;
  logic [7:0]    div;
  logic [7:0]    div_cnt;
  logic [7:0]    tx_data;
  logic [7:0]    rx_data;
  logic          tx_full;
  logic          rx_full;
  logic          rx_mpb;
  logic          rxd_s1;
  logic          rxd_s2;
  logic          rxd_s3;
  logic          sck_s1;
  logic          sck_s2;
  logic          sck_s3;
  logic [3:0]    tx_ph;
  logic [3:0]    tx_left;
  logic [11:0]   tx_sh;
  logic          sy_busy;
  logic          sy_tx;
  logic [3:0]    sy_cnt;
  logic [2:0]    hc;
  logic          sck_q;
  logic [3:0]    rx_ph;
  logic [3:0]    rx_cnt;
  logic [11:0]   rx_sh;
  logic          rx_done_q;

  // ************************************************************
  // Decode and clock selection
  // ************************************************************
  wire         wr_fmt   = wr_stb & (addr == OFF_FMT);
  wire         wr_ctl   = wr_stb & (addr == OFF_CTL);
  wire         wr_div   = wr_stb & (addr == OFF_DIV);
  wire         wr_tx    = wr_stb & (addr == OFF_TXD);
  wire         wr_clr   = wr_stb & (addr == OFF_CLR);
  wire         wr_ien   = wr_stb & (addr == OFF_IEN);
  wire         rd_rx    = rd_stb & (addr == OFF_RXD);

  wire         brg_tick = (div_cnt == div);
  // Pin edges count only while routing hands the pin to this block
  wire         ext_rise = sck_routed & sck_s2 & ~sck_s3;
  wire         ext_fall = sck_routed & ~sck_s2 & sck_s3;
  wire         tick16   = ctl.cke_hi ? ext_rise : brg_tick;

  wire         bit_edge = ~fmt.mode & tick16 & (tx_ph == PH_LAST);
  wire         sy_tog   = sy_busy & ~ctl.cke_hi & brg_tick & (hc == HALF_LAST);
  wire         s_rise   = sy_busy & (ctl.cke_hi ? ext_rise : sy_tog & ~sck_q);
  wire         s_fall   = sy_busy & (ctl.cke_hi ? ext_fall : sy_tog & sck_q);
  wire         tx_go    = tx_full & ctl.txen;
  wire         sy_start = fmt.mode & ~sy_busy & (tx_go | ctl.rxen);
  wire         sy_end   = s_rise & (sy_cnt == SYNC_LAST);

  wire         a_load   = bit_edge & (tx_left == 4'h0) & tx_go;
  wire         tx_load  = fmt.mode ? (sy_start & tx_go) : a_load;
  wire         tx_done  = fmt.mode ? (sy_end & sy_tx) : (bit_edge & (tx_left == ONE4));

  wire [3:0]   rx_n     = rx_bits(fmt);
  wire         rx_samp  = tick16 & (rx_ph == PH_SAMPLE);
  wire         rxd_fall = ~rxd_s2 & rxd_s3;
  wire         a_done   = (rx_st == RX_DATA) & rx_samp & ((rx_cnt + ONE4) == rx_n);
  wire         rx_done  = fmt.mode ? (sy_end & ctl.rxen) : a_done;

  wire scm_frame_t  frame = make_frame(fmt, tx_data, ctl.mpb_tx);
  wire scm_rx_res_t res   = decode_rx(fmt, rx_sh);

  // A second character arriving before the first is read is dropped
  wire         ovr_ev   = rx_done_q & rx_full;
  wire scm_evt_t set_ev = '{rsv: 2'h0,
                            brk: rx_done_q & res.brk,
                            perr: rx_done_q & res.perr,
                            ferr: rx_done_q & res.ferr,
                            ovr: ovr_ev,
                            tx_done: tx_done,
                            rx_ready: rx_done_q & ~rx_full};
  wire [7:0]   live     = {4'h0, sy_busy, tx_left != 4'h0, rx_mpb, rx_full};
  wire [7:0]   rd_mux   = (addr == OFF_FMT)  ? fmt :
                          (addr == OFF_CTL)  ? ctl :
                          (addr == OFF_DIV)  ? div :
                          (addr == OFF_TXD)  ? tx_data :
                          (addr == OFF_RXD)  ? rx_data :
                          (addr == OFF_STAT) ? stat :
                          (addr == OFF_IEN)  ? ien :
                          (addr == OFF_LIVE) ? live :
                          REG_RST;

  // Idle high on the async line is held by the all-ones fill of tx_sh
  assign txd    = tx_sh[0];
  assign sck_o  = fmt.mode ? sck_q : tx_ph[3];
  assign sck_oe = sck_routed & ~ctl.cke_hi & (fmt.mode | ctl.cke_lo);
  assign irq    = |(stat & ien);

  // ************************************************************
  // Register port and flags
  // ************************************************************
  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      fmt     <= REG_RST;
      ctl     <= REG_RST;
      div     <= REG_RST;
      ien     <= REG_RST;
      stat    <= REG_RST;
      tx_data <= REG_RST;
      rdata   <= REG_RST;
    end else begin
      if (wr_fmt) fmt <= wdata;
      if (wr_ctl) ctl <= wdata;
      if (wr_div) div <= wdata;
      if (wr_ien) ien <= wdata;
      if (wr_tx) tx_data <= wdata;
      stat  <= (stat & ~(wr_clr ? wdata : REG_RST)) | set_ev;
      rdata <= rd_stb ? rd_mux : REG_RST;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      tx_full   <= 1'h0;
      rx_full   <= 1'h0;
      rx_mpb    <= 1'h0;
      rx_data   <= REG_RST;
      rx_done_q <= 1'h0;
      div_cnt   <= REG_RST;
    end else begin
      tx_full   <= (tx_full & ~tx_load) | wr_tx;
      rx_full   <= (rx_full & ~rd_rx) | (rx_done_q & ~rx_full);
      rx_done_q <= rx_done;
      div_cnt   <= brg_tick ? REG_RST : div_cnt + 8'h01;
      if (rx_done_q & ~rx_full) begin
        rx_data <= res.data;
        rx_mpb  <= res.multiproc_frame_bit;
      end
    end
  end

  // ************************************************************
  // Pin synchronisers
  // ************************************************************
  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      rxd_s1 <= 1'h1;
      rxd_s2 <= 1'h1;
      rxd_s3 <= 1'h1;
      // Clock pin idles high; a low start would fake a rising edge
      sck_s1 <= 1'h1;
      sck_s2 <= 1'h1;
      sck_s3 <= 1'h1;
    end else begin
      rxd_s1 <= rxd;
      rxd_s2 <= rxd_s1;
      rxd_s3 <= rxd_s2;
      sck_s1 <= sck_i;
      sck_s2 <= sck_s1;
      sck_s3 <= sck_s2;
    end
  end

  // ************************************************************
  // Transmit shifter and clock generation
  // ************************************************************
  // Phase runs free so the async output clock keeps going between frames
  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      tx_ph   <= 4'h0;
      tx_left <= 4'h0;
      tx_sh   <= '1;
    end else begin
      if (tick16) tx_ph <= tx_ph + ONE4;
      if (tx_load) begin
        tx_sh   <= frame.bits;
        tx_left <= fmt.mode ? 4'h0 : frame.len;
      end else if (bit_edge & (tx_left != 4'h0)) begin
        tx_sh   <= {1'h1, tx_sh[11:1]};
        tx_left <= tx_left - ONE4;
      end else if (s_fall & (sy_cnt != 4'h0)) begin
        tx_sh   <= {1'h1, tx_sh[11:1]};
      end
    end
  end

  // Synchronous transfer: eight rising edges, internal clock idles high
  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      sy_busy <= 1'h0;
      sy_tx   <= 1'h0;
      sy_cnt  <= 4'h0;
      hc      <= 3'h0;
      sck_q   <= 1'h1;
    end else begin
      if (sy_start) begin
        sy_busy <= 1'h1;
        sy_tx   <= tx_go;
        sy_cnt  <= 4'h0;
        hc      <= 3'h0;
      end else if (sy_end) begin
        sy_busy <= 1'h0;
      end else if (s_rise) begin
        sy_cnt  <= sy_cnt + ONE4;
      end
      if (sy_busy & brg_tick) hc <= hc + 3'h1;
      if (sy_tog) sck_q <= ~sck_q;
      if (~sy_busy) sck_q <= 1'h1;
    end
  end

  // ************************************************************
  // Receiver
  // ************************************************************
  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      rx_st  <= RX_IDLE;
      rx_ph  <= 4'h0;
      rx_cnt <= 4'h0;
      rx_sh  <= 12'h000;
    end else if (fmt.mode) begin
      rx_st <= RX_IDLE;
      if (s_rise & ctl.rxen) rx_sh <= {rxd_s2, rx_sh[11:1]};
    end else begin
      if (tick16) rx_ph <= rx_ph + ONE4;
      unique case (rx_st)
        RX_IDLE: begin
          if (ctl.rxen & rxd_fall) begin
            rx_st <= RX_START;
            rx_ph <= 4'h0;
          end
        end
        RX_START: begin
          // A start bit gone high by mid-bit was a glitch
          if (rx_samp) begin
            rx_st  <= rxd_s2 ? RX_IDLE : RX_DATA;
            rx_cnt <= 4'h0;
          end
        end
        RX_DATA: begin
          if (rx_samp) begin
            rx_sh  <= {rxd_s2, rx_sh[11:1]};
            rx_cnt <= rx_cnt + ONE4;
            if (a_done) rx_st <= RX_IDLE;
          end
        end
        default: rx_st <= RX_IDLE;
      endcase
    end
  end

endmodule

// >>> scm_serial_sva.sv
// Port checker for the serial mode and clock block.
// Assumes a configuration write lands at the edge that takes wr_stb.
`timescale 1ns/1ps
module scm_serial_sva (
  input wire logic                       core_clk,
  input wire logic                       rst_b,
  input wire logic [scm_pkg::ADDR_W-1:0] addr,
  input wire logic [scm_pkg::DATA_W-1:0] wdata,
  input wire logic                       wr_stb,
  input wire logic                       rd_stb,
  input wire logic [scm_pkg::DATA_W-1:0] rdata,
  input wire logic                       txd,
  input wire logic                       sck_oe,
  input wire logic                       sck_routed,
  input wire logic                       irq
);
  import scm_pkg::*;
  // ****************
  // Configuration shadow
  // ****************
  logic       mode;
  logic [1:0] cke;
  logic [7:0] div;
  logic [7:0] ien;
  wire        unmapped = addr > OFF_LIVE || addr[1:0] != 2'h0;
  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      mode <= 1'b0;
      cke <= 2'h0;
      div <= 8'h00;
      ien <= 8'h00;
    end else if (wr_stb) begin
      if (addr == OFF_FMT) mode <= wdata[7];
      if (addr == OFF_CTL) cke <= wdata[1:0];
      if (addr == OFF_DIV) div <= wdata;
      if (addr == OFF_IEN) ien <= wdata;
    end
  end
  // ****************
  // Properties
  // ****************
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_b);
  // A bit at divider zero lasts sixteen clocks, so any fall holds that long
  sequence low_half;
    (!txd) [*8];
  endsequence
  sequence low_bit;
    low_half ##1 low_half;
  endsequence
  a_rdata_idle: assert property (!$past(rd_stb) |-> rdata == 8'h00)
    else $error("read data not zero outside an answer");
  a_unmapped_rd: assert property (rd_stb && unmapped |=> rdata == 8'h00)
    else $error("unmapped read returned data");
  a_oe_routed: assert property (!sck_routed |-> !sck_oe)
    else $error("clock pin driven while not routed");
  a_async_quiet: assert property (!mode && cke == 2'h0 |-> !sck_oe)
    else $error("clock pin driven with internal clock and no output");
  a_async_clkout: assert property (!mode && cke == 2'h1 && sck_routed |-> sck_oe)
    else $error("bit rate clock not driven");
  a_ext_input: assert property (cke[1] |-> !sck_oe)
    else $error("clock pin driven while external clock chosen");
  a_sync_clkout: assert property (mode && !cke[1] && sck_routed |-> sck_oe)
    else $error("synchronous clock not driven");
  a_start_len: assert property (!mode && div == 8'h00 && $fell(txd) |-> low_bit)
    else $error("low bit shorter than sixteen clocks");
  a_irq_masked: assert property ((ien == 8'h00) [*2] |-> !irq)
    else $error("interrupt high with all enables clear");
endmodule

bind scm_serial scm_serial_sva u_sva (.core_clk(core_clk), .rst_b(rst_b), .addr(addr),
  .wdata(wdata), .wr_stb(wr_stb), .rd_stb(rd_stb), .rdata(rdata), .txd(txd),
  .sck_oe(sck_oe), .sck_routed(sck_routed), .irq(irq));

// >>> scm_peer.sv
// Far-side serial device: drives the receive line and an external clock
// and captures frames from the transmit line. Bits are paced by core_clk.
`timescale 1ns/1ps
module scm_peer (
  input  wire logic core_clk,
  input  wire logic txd,
  input  wire logic ext_on,
  output logic      rxd,
  output logic      sck_i
);
  // ****************
  // External clock and line driver
  // ****************
  logic [1:0] ext_cnt = 2'h0;
  initial rxd = 1'b1;
  initial sck_i = 1'b1;
  // Period of 8 core clocks: a bit of 128 clocks is 16 ticks
  always @(posedge core_clk) begin
    ext_cnt <= ext_cnt + 2'h1;
    if (ext_on && ext_cnt == 2'h3) sck_i <= ~sck_i;
  end
  task automatic send(input logic [11:0] bits, input int n, input int bclk);
    for (int i = 0; i < n; i++) begin
      rxd <= bits[i];
      repeat (bclk) @(posedge core_clk);
    end
    rxd <= 1'b1;
  endtask
  // Samples mid-bit at divider zero; gives up on the start after 400 clocks
  task automatic grab(input int n, output logic [11:0] bits);
    int k;
    bits = 12'hFFF;
    k = 0;
    while (txd !== 1'b0 && k < 400) begin
      @(posedge core_clk);
      k++;
    end
    repeat (8) @(posedge core_clk);
    for (int i = 0; i < n; i++) begin
      bits[i] = txd;
      repeat (16) @(posedge core_clk);
    end
  endtask
endmodule

// >>> tb_top.sv
// Self-checking bench for the serial mode and clock block.
// Assumes the checker is bound in and the peer paces bits off core_clk.
`timescale 1ns/1ps
module tb_top;
  import scm_pkg::*;
  // ****************
  // Signals and instances
  // ****************
  logic              core_clk, rst_b, wr_stb, rd_stb, sck_routed, ext_on;
  logic              rxd, txd, sck_i, sck_o, sck_oe, irq;
  logic [ADDR_W-1:0] addr;
  logic [DATA_W-1:0] wdata, rdata, d;
  logic [11:0]       got;
  logic [15:0]       fx;
  logic [7:0]        rv [7] = '{OFF_FMT, OFF_CTL, OFF_DIV, OFF_STAT, OFF_IEN, 8'h24, 8'h03};
  logic [7:0]        tf [4] = '{8'h00, 8'h68, 8'h24, 8'h30};
  logic [7:0]        tc [4] = '{8'h21, 8'h20, 8'h60, 8'h20};
  logic [7:0]        ef [3] = '{8'h60, 8'h00, 8'h00};
  logic [7:0]        ed [3] = '{8'h35, 8'h00, 8'hA5};
  logic [11:0]       em [3] = '{12'h100, 12'h200, 12'h200};
  logic [7:0]        es [3] = '{8'h10, 8'h28, 8'h08};
  int                miscompares = 0, n_compared = 0, seed = 52, cyc = 0;
  initial core_clk = 1'b0;
  always #4 core_clk = ~core_clk;
  scm_serial DUT (.core_clk(core_clk), .rst_b(rst_b), .addr(addr), .wdata(wdata),
    .wr_stb(wr_stb), .rd_stb(rd_stb), .rdata(rdata), .rxd(rxd), .txd(txd), .sck_i(sck_i),
    .sck_o(sck_o), .sck_oe(sck_oe), .sck_routed(sck_routed), .irq(irq));
  scm_peer peer (.core_clk(core_clk), .txd(txd), .ext_on(ext_on), .rxd(rxd), .sck_i(sck_i));
  // ****************
  // Helpers
  // ****************
  task automatic close_out();
    $display("compared %0d, miscompares %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  always @(posedge core_clk) begin
    cyc <= cyc + 1;
    if (cyc == 30000) begin
      miscompares++;
      close_out();
    end
  end
  task automatic chk(input string w, input logic [11:0] e, input logic [11:0] g);
    n_compared++;
    if (g !== e) begin
      miscompares++;
      $display("BAD %s expected %h seen %h", w, e, g);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] x);
    @(posedge core_clk);
    addr <= a;
    wdata <= x;
    wr_stb <= 1'b1;
    @(posedge core_clk);
    wr_stb <= 1'b0;
  endtask
  task automatic rdc(input string w, input logic [7:0] a, input logic [7:0] m,
                     input logic [7:0] e);
    @(posedge core_clk);
    addr <= a;
    rd_stb <= 1'b1;
    @(posedge core_clk);
    rd_stb <= 1'b0;
    @(negedge core_clk);
    chk(w, {4'h0, e}, {4'h0, rdata & m});
  endtask
  // Expected frame: length in the top nibble, bits from the start bit up
  function automatic logic [15:0] frame(input logic [7:0] f, input logic m, input logic [7:0] x);
    logic [11:0] b;
    int          n;
    int          k;
    b = 12'hFFF;
    b[0] = 1'b0;
    k = f[6] ? 7 : 8;
    for (int i = 0; i < k; i++) b[i + 1] = x[i];
    n = k + 1;
    if (f[2]) begin
      b[n] = m;
      n++;
    end else if (f[5]) begin
      b[n] = ^(x & (f[6] ? MASK7 : MASK8)) ^ f[4];
      n++;
    end
    n = n + 1 + int'(f[3]);
    return {4'(n), b};
  endfunction
  task automatic rx_char(input logic [7:0] f, input logic [11:0] flip, input logic [7:0] x,
                         input int bclk);
    fx = frame(f, 1'b0, x);
    peer.send(fx[11:0] ^ flip, int'(fx[15:12]), bclk);
    repeat (8) @(posedge core_clk);
  endtask
  // ****************
  // Scenarios
  // ****************
  initial begin
    {rst_b, wr_stb, rd_stb, addr, wdata, ext_on} = '0;
    sck_routed = 1'b1;
    repeat (10) @(posedge core_clk);
    rst_b <= 1'b1;
    foreach (rv[i]) rdc("reset value", rv[i], 8'hFF, REG_RST);
    wr(OFF_DIV, 8'h00);
    foreach (tf[j]) begin
      wr(OFF_CTL, 8'h00);
      wr(OFF_FMT, tf[j]);
      wr(OFF_CTL, tc[j]);
      d = 8'($random(seed));
      wr(OFF_TXD, d);
      fx = frame(tf[j], tc[j][6], d);
      peer.grab(int'(fx[15:12]), got);
      chk("tx frame", fx[11:0], got);
    end
    wr(OFF_CTL, 8'h00);
    wr(OFF_FMT, 8'h00);
    wr(OFF_CTL, 8'h10);
    wr(OFF_CLR, 8'hFF);
    d = 8'($random(seed));
    rx_char(8'h00, 12'h000, d, 16);
    rdc("rx data", OFF_RXD, 8'hFF, d);
    rdc("rx ready", OFF_STAT, 8'h3D, 8'h01);
    foreach (ef[j]) begin
      wr(OFF_CTL, 8'h00);
      wr(OFF_FMT, ef[j]);
      wr(OFF_CTL, 8'h10);
      wr(OFF_CLR, 8'hFF);
      rx_char(ef[j], em[j], ed[j], 16);
      rdc("rx errors", OFF_STAT, 8'h3C, es[j]);
      rdc("rx drain", OFF_RXD, 8'hFF, ed[j]);
    end
    wr(OFF_CLR, 8'hFF);
    wr(OFF_IEN, 8'h04);
    rx_char(8'h00, 12'h000, 8'h5A, 16);
    rx_char(8'h00, 12'h000, 8'hC3, 16);
    @(negedge core_clk);
    chk("irq raised", 12'h001, {11'h0, irq});
    rdc("overrun", OFF_STAT, 8'h04, 8'h04);
    rdc("rx full", OFF_LIVE, 8'h01, 8'h01);
    rdc("kept char", OFF_RXD, 8'hFF, 8'h5A);
    wr(OFF_IEN, 8'h00);
    repeat (2) @(negedge core_clk);
    chk("irq masked", 12'h000, {11'h0, irq});
    wr(OFF_IEN, 8'h04);
    wr(OFF_CLR, 8'h04);
    repeat (2) @(negedge core_clk);
    chk("irq cleared", 12'h000, {11'h0, irq});
    wr(OFF_CTL, 8'h00);
    ext_on <= 1'b1;
    wr(OFF_CTL, 8'h12);
    repeat (20) @(posedge core_clk);
    d = 8'($random(seed));
    rx_char(8'h00, 12'h000, d, 128);
    rdc("ext clock rx", OFF_RXD, 8'hFF, d);
    chk("ext clock pin", 12'h000, {11'h0, sck_oe});
    ext_on <= 1'b0;
    wr(OFF_CTL, 8'h00);
    wr(OFF_FMT, 8'hEC);
    repeat (40) @(posedge core_clk);
    wr(OFF_CTL, 8'h20);
    wr(OFF_CLR, 8'hFF);
    @(negedge core_clk);
    chk("sync clock pin", 12'h001, {11'h0, sck_oe});
    d = 8'($random(seed)) | 8'h80;
    wr(OFF_TXD, d);
    for (int i = 0; i < 8; i++) begin
      @(posedge sck_o);
      got[i] = txd;
    end
    chk("sync bits", {4'h0, d}, {4'h0, got[7:0]});
    repeat (40) @(posedge core_clk);
    rdc("sync done", OFF_STAT, 8'h02, 8'h02);
    // Receive with the internal clock: bits start mid-way between clock rises
    d = 8'($random(seed));
    wr(OFF_CTL, 8'h10);
    repeat (8) @(posedge core_clk);
    peer.send({4'h0, d}, 8, 16);
    rdc("sync errors", OFF_STAT, 8'h39, 8'h01);
    rdc("sync rx", OFF_RXD, 8'hFF, d);
    wr(OFF_CTL, 8'h22);
    @(negedge core_clk);
    chk("sync ext pin", 12'h000, {11'h0, sck_oe});
    wr(OFF_CTL, 8'h20);
    sck_routed <= 1'b0;
    @(negedge core_clk);
    chk("unrouted pin", 12'h000, {11'h0, sck_oe});
    close_out();
  end
endmodule
